// [core/pllc_pkg.sv]
// package of register offsets, fields and reset values for the pll control block
package pllc_pkg;
  localparam logic [7:0]  PLLC_CFG_OFS      = 8'h00;
  localparam logic [7:0]  PLLC_NDIV_OFS     = 8'h04;
  localparam logic [7:0]  PLLC_OUTEN_OFS    = 8'h08;
  localparam logic [7:0]  PLLC_STAT_OFS     = 8'h0C;
  localparam logic [7:0]  PLLC_IRQ_OFS      = 8'h10;
  localparam logic [7:0]  PLLC_MASK_OFS     = 8'h14;
  localparam logic [7:0]  PLLC_RDIV_OFS     = 8'h18;
  localparam int          PLLC_SEL_LSB      = 20;
  localparam int          PLLC_SEL_MSB      = 23;
  localparam int          PLLC_POL_BIT      = 24;
  localparam int          PLLC_TRI_BIT      = 25;
  localparam int          PLLC_SLEEP_BIT    = 26;
  localparam int          PLLC_GOE_BIT      = 27;
  localparam int          PLLC_GAIN_LSB     = 30;
  localparam int          PLLC_NDIV_W       = 18;
  localparam int          PLLC_RDIV_W       = 12;
  localparam logic [3:0]  PLLC_SEL_RST      = 4'h0;
  localparam logic [17:0] PLLC_NDIV_RST     = 18'h002F8;
  localparam logic [11:0] PLLC_RDIV_RST     = 12'h00A;
  localparam logic [1:0]  PLLC_GAIN_RST     = 2'h0;
  localparam logic [7:0]  PLLC_OUTEN_RST    = 8'h00;
  localparam logic [3:0]  PLLC_SEL_HIZ      = 4'h0;
  localparam logic [3:0]  PLLC_SEL_HIGH     = 4'h1;
  localparam logic [3:0]  PLLC_SEL_LOW      = 4'h2;
  localparam logic [3:0]  PLLC_SEL_LOCK     = 4'h3;
  localparam logic [3:0]  PLLC_SEL_LOCK_N   = 4'h4;
  localparam logic [3:0]  PLLC_SEL_FBHALF   = 4'h9;
  localparam logic [3:0]  PLLC_SEL_REFHALF  = 4'hB;
  localparam int          PLLC_IRQ_W        = 3;
  typedef logic [1:0] pllc_resp_t;
  localparam pllc_resp_t  PLLC_OKAY         = 2'h0;
  localparam pllc_resp_t  PLLC_SLVERR       = 2'h2;
endpackage : pllc_pkg

// [core/pllc_div_if.sv]
// interface carrying divider settings and terminal-count pulses
`timescale 1ns/100ps
`default_nettype none
interface pllc_div_if;
  logic [17:0] modulus;
  logic        run;
  logic        tc;
  modport ctrl (output modulus, output run, input tc);
  modport div  (input modulus, input run, output tc);
endinterface : pllc_div_if
`default_nettype wire

// [core/pllc_div.sv]
// programmable divider producing one terminal-count pulse per modulus input edges
`timescale 1ns/100ps
`default_nettype none
module pllc_div (
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ref_edge_i,
  pllc_div_if.div    bus
);
  logic [17:0] count_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= 18'h00000;
      bus.tc    <= 1'b0;
    end else if (!bus.run || bus.modulus == 18'h00000) begin
      count_reg <= 18'h00000;
      bus.tc    <= 1'b0;
    end else if (ref_edge_i) begin
      if (count_reg >= bus.modulus - 18'h00001) begin
        count_reg <= 18'h00000;
        bus.tc    <= 1'b1;
      end else begin
        count_reg <= count_reg + 18'h00001;
        bus.tc    <= 1'b0;
      end
    end else begin
      bus.tc <= 1'b0;
    end
  end
endmodule : pllc_div
`default_nettype wire

// [core/pllc_top.sv]
// pll control: lock pin selector, power and output enables, dividers, axi
`timescale 1ns/100ps
`default_nettype none
module pllc_top
  import pllc_pkg::*;
#(
  parameter int N_OUT = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               vco_edge_i,
  input  wire logic               ref_edge_i,
  input  wire logic               phase_match_i,
  input  wire logic               goe_pin_i,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    lock_status_pin_o,
  output logic                    lock_status_pin_oe_b_o,
  output logic [N_OUT-1:0]        output_enable_o,
  output logic                    low_buffer_en_o,
  output logic                    high_buffer_en_o,
  output logic                    device_sleep_o,
  output logic                    pump_high_impedance_o,
  output logic                    pump_polarity_o,
  output logic [5:0]              pump_gain_mult_o,
  output logic [17:0]             feedback_modulus_o,
  output logic                    irq_o
);
  import pllc_pkg::*;

  logic        rst_s1_reg, rst_b;
  logic [2:0]  vco_sync_reg, ref_sync_reg, lock_sync_reg;
  logic [1:0]  goe_sync_reg;
  logic        vco_rise, ref_rise;
  logic [31:0] cfg_reg;
  logic [17:0] ndiv_reg;
  logic [11:0] rdiv_reg;
  logic [N_OUT-1:0] outen_reg;
  logic [PLLC_IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_event;
  logic        fb_half_reg, ref_half_reg;
  logic        lock_prev_reg;
  logic [3:0]  sel;
  logic        sleep, global_en, locked;
  logic        aw_held_reg, w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_go;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [31:0] wr_mask, ndiv_wide, rdiv_wide;

  pllc_div_if fb_if ();
  pllc_div_if rf_if ();

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_reg <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_b      <= rst_s1_reg;
    end
  end

  // pin inputs pass two flops; third stage for edge detection and for the lock level
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      vco_sync_reg  <= 3'h0;
      ref_sync_reg  <= 3'h0;
      lock_sync_reg <= 3'h0;
      goe_sync_reg  <= 2'h0;
    end else begin
      vco_sync_reg  <= {vco_sync_reg[1:0], vco_edge_i};
      ref_sync_reg  <= {ref_sync_reg[1:0], ref_edge_i};
      lock_sync_reg <= {lock_sync_reg[1:0], phase_match_i};
      goe_sync_reg  <= {goe_sync_reg[0], goe_pin_i};
    end
  end
  assign vco_rise = vco_sync_reg[1] & ~vco_sync_reg[2];
  assign ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];
  assign locked   = lock_sync_reg[2];

  assign sel       = cfg_reg[PLLC_SEL_MSB:PLLC_SEL_LSB];
  assign sleep     = cfg_reg[PLLC_SLEEP_BIT];
  assign global_en = cfg_reg[PLLC_GOE_BIT] & goe_sync_reg[1];

  // feedback divider counts vco edges ahead of the phase detector
  assign fb_if.modulus = ndiv_reg;
  assign fb_if.run     = ~sleep;
  assign rf_if.modulus = {6'h00, rdiv_reg};
  assign rf_if.run     = ~sleep;

  pllc_div u_fb_div (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b),
    .ref_edge_i (vco_rise),
    .bus        (fb_if.div)
  );

  pllc_div u_ref_div (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b),
    .ref_edge_i (ref_rise),
    .bus        (rf_if.div)
  );

  // halved divider outputs
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      fb_half_reg  <= 1'b0;
      ref_half_reg <= 1'b0;
    end else begin
      if (fb_if.tc) fb_half_reg <= ~fb_half_reg;
      if (rf_if.tc) ref_half_reg <= ~ref_half_reg;
    end
  end

  // lock pin selector
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      lock_status_pin_o      <= 1'b0;
      lock_status_pin_oe_b_o <= 1'b1;
    end else if (sleep) begin
      lock_status_pin_o      <= 1'b0;
      lock_status_pin_oe_b_o <= 1'b1;
    end else begin
      lock_status_pin_oe_b_o <= 1'b0;
      unique case (sel)
        PLLC_SEL_HIGH:    lock_status_pin_o <= 1'b1;
        PLLC_SEL_LOW:     lock_status_pin_o <= 1'b0;
        PLLC_SEL_LOCK:    lock_status_pin_o <= locked;
        PLLC_SEL_LOCK_N:  lock_status_pin_o <= ~locked;
        PLLC_SEL_FBHALF:  lock_status_pin_o <= fb_half_reg;
        PLLC_SEL_REFHALF: lock_status_pin_o <= ref_half_reg;
        default: begin
          lock_status_pin_o      <= 1'b0;
          lock_status_pin_oe_b_o <= 1'b1;
        end
      endcase
    end
  end

  // clock output gating and group buffers
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      output_enable_o  <= '0;
      low_buffer_en_o  <= 1'b0;
      high_buffer_en_o <= 1'b0;
    end else begin
      output_enable_o  <= (global_en && !sleep) ? outen_reg : '0;
      low_buffer_en_o  <= global_en && !sleep
                          && (|outen_reg[3:0]);
      high_buffer_en_o <= global_en && !sleep
                          && (|outen_reg[N_OUT-1:4]);
    end
  end

  // pump controls
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      device_sleep_o        <= 1'b0;
      pump_high_impedance_o <= 1'b0;
      pump_polarity_o       <= 1'b0;
      pump_gain_mult_o      <= 6'h01;
      feedback_modulus_o    <= PLLC_NDIV_RST;
    end else begin
      device_sleep_o        <= sleep;
      pump_high_impedance_o <= cfg_reg[PLLC_TRI_BIT] | sleep;
      pump_polarity_o       <= cfg_reg[PLLC_POL_BIT];
      feedback_modulus_o    <= ndiv_reg;
      unique case (cfg_reg[PLLC_GAIN_LSB +: 2])
        2'h0: pump_gain_mult_o <= 6'h01;
        2'h1: pump_gain_mult_o <= 6'h04;
        2'h2: pump_gain_mult_o <= 6'h10;
        2'h3: pump_gain_mult_o <= 6'h20;
      endcase
    end
  end

  // events: lock gained, lock lost, selector code 8, A or C to F written
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) lock_prev_reg <= 1'b0;
    else        lock_prev_reg <= locked;
  end
  assign irq_event[0] = locked & ~lock_prev_reg;
  assign irq_event[1] = ~locked & lock_prev_reg;
  assign irq_event[2] = wr_go && awaddr_reg == PLLC_CFG_OFS && wstrb_reg[2]
                        && (wdata_reg[23:20] == 4'h8
                            || wdata_reg[23:20] == 4'hA
                            || wdata_reg[23:20] >= 4'hC);

  // axi write channel: address and data taken in either order
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= PLLC_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg > PLLC_RDIV_OFS
                         || awaddr_reg == PLLC_STAT_OFS)
                        ? PLLC_SLVERR : PLLC_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte lanes without a strobe keep their old contents
  assign wr_mask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                      {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign ndiv_wide = ({14'h0000, ndiv_reg} & ~wr_mask)
                     | (wdata_reg & wr_mask);
  assign rdiv_wide = ({20'h00000, rdiv_reg} & ~wr_mask)
                     | (wdata_reg & wr_mask);

  // register file with byte strobes
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= 32'h00000000 | (32'h1 << PLLC_GOE_BIT);
      ndiv_reg     <= PLLC_NDIV_RST;
      rdiv_reg     <= PLLC_RDIV_RST;
      outen_reg    <= PLLC_OUTEN_RST;
      irq_mask_reg <= '0;
    end else if (wr_go) begin
      unique case (awaddr_reg)
        PLLC_CFG_OFS:   cfg_reg <= (cfg_reg & ~wr_mask)
                                   | (wdata_reg & wr_mask);
        PLLC_NDIV_OFS:  ndiv_reg <= ndiv_wide[PLLC_NDIV_W-1:0];
        PLLC_RDIV_OFS:  rdiv_reg <= rdiv_wide[PLLC_RDIV_W-1:0];
        PLLC_OUTEN_OFS: if (wstrb_reg[0]) outen_reg <= wdata_reg[N_OUT-1:0];
        PLLC_MASK_OFS:  if (wstrb_reg[0]) irq_mask_reg <=
                          wdata_reg[PLLC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status: set wins over write-one-to-clear
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) irq_stat_reg <= '0;
    else if (wr_go && awaddr_reg == PLLC_IRQ_OFS && wstrb_reg[0])
      irq_stat_reg <= (irq_stat_reg & ~wdata_reg[PLLC_IRQ_W-1:0])
                      | irq_event;
    else
      irq_stat_reg <= irq_stat_reg | irq_event;
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) irq_o <= 1'b0;
    else        irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  // read channel
  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      PLLC_CFG_OFS:   rd_val = cfg_reg;
      PLLC_NDIV_OFS:  rd_val = {14'h0000, ndiv_reg};
      PLLC_RDIV_OFS:  rd_val = {20'h00000, rdiv_reg};
      PLLC_OUTEN_OFS: rd_val = {24'h000000, outen_reg};
      PLLC_STAT_OFS:  rd_val = {27'h0000000, ref_half_reg, fb_half_reg,
                                global_en, low_buffer_en_o | high_buffer_en_o,
                                locked};
      PLLC_IRQ_OFS:   rd_val = {29'h00000000, irq_stat_reg};
      PLLC_MASK_OFS:  rd_val = {29'h00000000, irq_mask_reg};
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= PLLC_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? PLLC_OKAY : PLLC_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : pllc_top
`default_nettype wire

// [tb/pllc_top_chk.sv]
// port-level assertions for the pll control block
`timescale 1ns/100ps
`default_nettype none
module pllc_top_chk
  import pllc_pkg::*;
#(
  parameter int N_OUT = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_b_i,
  input wire logic             goe_pin_i,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             lock_status_pin_oe_b_o,
  input wire logic [N_OUT-1:0] output_enable_o,
  input wire logic             low_buffer_en_o,
  input wire logic             high_buffer_en_o,
  input wire logic             device_sleep_o,
  input wire logic             pump_high_impedance_o,
  input wire logic [5:0]       pump_gain_mult_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence sleep_held;
    device_sleep_o [*2];
  endsequence
  sequence outen_steady;
    $stable(output_enable_o) [*2];
  endsequence
  a_low_buffer: assert property (
    outen_steady |-> low_buffer_en_o == |output_enable_o[3:0])
    else $error("low buffer enable wrong");
  a_high_buffer: assert property (
    outen_steady |-> high_buffer_en_o == |output_enable_o[7:4])
    else $error("high buffer enable wrong");
  a_sleep_quiet: assert property (
    sleep_held |-> output_enable_o == '0 && pump_high_impedance_o
      && lock_status_pin_oe_b_o)
    else $error("block active while asleep");
  a_goe_pin_off: assert property (
    !goe_pin_i [*5] |-> output_enable_o == '0)
    else $error("outputs on with enable pin low");
  a_gain_legal: assert property (
    pump_gain_mult_o inside {6'h01, 6'h04, 6'h10, 6'h20})
    else $error("illegal pump gain");
  a_pin_drive_cause: assert property (
    $fell(lock_status_pin_oe_b_o) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("lock pin driven without a write");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_slverr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == PLLC_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returns data");
  a_aw_taken: assert property (
    s_axi_awvalid && !s_axi_awready |-> ##[1:3] s_axi_awready)
    else $error("write address not taken");
endmodule : pllc_top_chk
`default_nettype wire

// [tb/pllc_top_tb_top.sv]
// self-checking bench for the pll control block
`timescale 1ns/100ps
`default_nettype none
module pllc_top_tb_top;
  import pllc_pkg::*;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, phase_match_i = 1'b0;
  logic        vco_edge_i = 1'b0, ref_edge_i = 1'b0, goe_pin_i = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF, div_cnt = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_rvalid, lock_status_pin_o, lock_status_pin_oe_b_o;
  logic [7:0]  output_enable_o, en;
  logic        low_buffer_en_o, high_buffer_en_o, device_sleep_o, irq_o;
  logic        pump_high_impedance_o, pump_polarity_o, gb, gp, lk, prev;
  logic [5:0]  pump_gain_mult_o;
  logic [17:0] feedback_modulus_o, nv;
  logic [3:0]  codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hA,
                              4'hC, 4'hD, 4'hE, 4'hF};
  int          mismatches = 0;
  int          cmp_count = 0;
  int          tog, hi;

  pllc_top #(.N_OUT(8)) DUT (.*);

  always #20 clk_i = ~clk_i;

  // both divider inputs toggle every four cycles
  always @(posedge clk_i) begin
    div_cnt <= div_cnt + 4'h1;
    if (div_cnt[1:0] == 2'h3) begin
      vco_edge_i <= ~vco_edge_i;
      ref_edge_i <= ~ref_edge_i;
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er), "read response");
  endtask : rd

  function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic l);
    case (c)
      4'h1: return 2'h1;
      4'h2: return 2'h0;
      4'h3: return {1'b0, l};
      4'h4: return {1'b0, ~l};
      default: return 2'h2;
    endcase
  endfunction : exp_pin

  function automatic logic [5:0] exp_gain(input logic [1:0] g);
    case (g)
      2'h0: return 6'h01;
      2'h1: return 6'h04;
      2'h2: return 6'h10;
      default: return 6'h20;
    endcase
  endfunction : exp_gain

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(97126));
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(PLLC_CFG_OFS, PLLC_OKAY);
    chk(d, 32'h0800_0000, "config reset");
    rd(PLLC_NDIV_OFS, PLLC_OKAY);
    chk(d, 32'h0000_02F8, "divider reset");
    chk(32'(feedback_modulus_o), 32'h0000_02F8, "modulus reset");
    chk(32'(lock_status_pin_oe_b_o), 32'h1, "pin reset");
    chk(32'(pump_gain_mult_o), 32'h1, "gain reset");
    rd(8'h1C, PLLC_SLVERR);
    chk(d, 32'h0, "unmapped read");
    wr(PLLC_STAT_OFS, 32'hFFFF_FFFF, PLLC_SLVERR);
    $display("test reset done");
    for (int l = 0; l < 2; l++) begin
      phase_match_i <= l[0];
      foreach (codes[i]) begin
        wr(PLLC_CFG_OFS, 32'h0800_0000 | (32'(codes[i]) << 20), PLLC_OKAY);
        repeat (6) @(posedge clk_i);
        lk = exp_pin(codes[i], l[0]) >> 1;
        chk(32'(lock_status_pin_oe_b_o), 32'(lk), "pin drive");
        if (!lk) chk(32'(lock_status_pin_o),
                     32'(exp_pin(codes[i], l[0]) & 2'h1), "pin level");
        rd(PLLC_CFG_OFS, PLLC_OKAY);
        chk(32'(d[23:20]), 32'(codes[i]), "selector field");
      end
    end
    $display("test selector done");
    for (int g = 0; g < 4; g++) begin
      wr(PLLC_CFG_OFS, 32'h0800_0000 | (32'(g) << 30) | (32'(g) << 24),
         PLLC_OKAY);
      repeat (3) @(posedge clk_i);
      chk(32'(pump_gain_mult_o), 32'(exp_gain(g[1:0])), "gain");
      chk(32'(pump_polarity_o), 32'(g[0]), "polarity");
      chk(32'(pump_high_impedance_o), 32'(g[1]), "pump off");
    end
    $display("test pump done");
    wr(PLLC_OUTEN_OFS, 32'h0000_00FF, PLLC_OKAY);
    wr(PLLC_CFG_OFS, 32'h0C10_0000, PLLC_OKAY);
    repeat (3) @(posedge clk_i);
    chk({device_sleep_o, pump_high_impedance_o, lock_status_pin_oe_b_o,
         output_enable_o}, 32'h0000_0700, "sleep");
    wr(PLLC_CFG_OFS, 32'h0810_0000, PLLC_OKAY);
    repeat (3) @(posedge clk_i);
    chk(32'(output_enable_o), 32'h0000_00FF, "wake");
    $display("test sleep done");
    for (int i = 0; i < 10; i++) begin
      en = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
      gb = (i < 3) ? 1'b1 : 1'($urandom);
      gp = (i < 2) ? 1'b1 : (i == 2) ? 1'b0 : 1'($urandom);
      goe_pin_i <= gp;
      wr(PLLC_OUTEN_OFS, 32'(en), PLLC_OKAY);
      wr(PLLC_CFG_OFS, 32'(gb) << 27, PLLC_OKAY);
      repeat (6) @(posedge clk_i);
      en = (gb && gp) ? en : 8'h00;
      chk(32'(output_enable_o), 32'(en), "enables");
      chk(32'(low_buffer_en_o), 32'(|en[3:0]), "low buffer");
      chk(32'(high_buffer_en_o), 32'(|en[7:4]), "high buffer");
    end
    goe_pin_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      nv = (i == 0) ? 18'h00001 : (i == 1) ? 18'h3FFFF
                    : 18'($urandom_range(18'h3FFFF, 1));
      wr(PLLC_NDIV_OFS, 32'(nv), PLLC_OKAY);
      repeat (3) @(posedge clk_i);
      chk(32'(feedback_modulus_o), 32'(nv), "modulus");
      rd(PLLC_NDIV_OFS, PLLC_OKAY);
      chk(d, 32'(nv), "divider readback");
    end
    $display("test enables done");
    wr(PLLC_NDIV_OFS, 32'h2, PLLC_OKAY);
    wr(PLLC_RDIV_OFS, 32'h2, PLLC_OKAY);
    for (int c = 9; c < 12; c += 2) begin
      wr(PLLC_CFG_OFS, 32'h0800_0000 | (32'(c) << 20), PLLC_OKAY);
      repeat (8) @(posedge clk_i);
      tog = 0;
      hi = 0;
      prev = lock_status_pin_o;
      repeat (160) begin
        @(posedge clk_i);
        tog += (lock_status_pin_o !== prev);
        hi += (lock_status_pin_o === 1'b1);
        prev = lock_status_pin_o;
      end
      // two source edges per toggle, so ten toggles in the window
      chk(32'(tog inside {[9:11]} && hi inside {[72:88]}), 32'h1,
          "halved output");
    end
    $display("test halved done");
    // a mask bit of one lets its status bit reach the interrupt
    wr(PLLC_MASK_OFS, 32'h1, PLLC_OKAY);
    phase_match_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wr(PLLC_IRQ_OFS, 32'h7, PLLC_OKAY);
    phase_match_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(PLLC_IRQ_OFS, PLLC_OKAY);
    chk({d[0], 31'(irq_o)}, 32'h8000_0001, "lock event");
    wr(PLLC_MASK_OFS, 32'h0, PLLC_OKAY);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0, "masked");
    wr(PLLC_MASK_OFS, 32'h1, PLLC_OKAY);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h1, "unmasked again");
    wr(PLLC_IRQ_OFS, 32'h1, PLLC_OKAY);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0, "cleared");
    wr(PLLC_CFG_OFS, 32'h0880_0000, PLLC_OKAY);
    rd(PLLC_IRQ_OFS, PLLC_OKAY);
    chk(32'(d[2]), 32'h1, "reserved code event");
    $display("test interrupt done");
    print_verdict();
  end
endmodule : pllc_top_tb_top

bind pllc_top pllc_top_chk #(.N_OUT(N_OUT)) u_chk (.*);
`default_nettype wire
